// ---- design/cac_pkg.sv ----
// ****************************************
// Shared constants for the add/slot checker
// ****************************************
`default_nettype none
package cac_pkg;

    // ****************************************
    // Register offsets (byte addresses)
    // ****************************************
    localparam logic [6:0] OFF_STATUS = 7'h00; // status_word
    localparam logic [6:0] OFF_EXC = 7'h04; // last exception code
    localparam logic [6:0] OFF_PCSEEN = 7'h08; // last PC seen by code
    localparam logic [6:0] OFF_ACCADDR = 7'h0C; // last access address
    localparam logic [6:0] OFF_GPR = 7'h40; // 16 general registers

    // ****************************************
    // status_word layout, LSB upward
    // ****************************************
    localparam int ST_T = 0; // Carry / test flag
    localparam int ST_S = 1; // Saturation
    localparam int ST_BANK_LO = 2; // bank_select_low
    localparam int ST_BANK_HI = 3; // bank_select_high
    localparam int ST_I_LO = 4; // Interrupt mask, 4 bits
    localparam int ST_Q = 8; // Quotient
    localparam int ST_M = 9; // Divisor
    localparam int ST_MOD_X = 10; // modulo_x_enable
    localparam int ST_MOD_Y = 11; // modulo_y_enable
    localparam int ST_RPT_LO = 16; // repeat_counter, 12 bits
    localparam logic [31:0] ST_MASK = 32'h0FFF0FFF; // Unused bits read 0
    localparam logic [31:0] ST_RESET = 32'h00000000;

    // ****************************************
    // Opcode fields and timing
    // ****************************************
    localparam logic [3:0] OP_REGOP = 4'h3; // Two-register group
    localparam logic [3:0] OP_ADDI = 4'h7; // Immediate add
    localparam logic [3:0] LO_ADD = 4'hC; // Register add
    localparam logic [3:0] LO_SUM_WITH_FLAG_INSTRUCTION = 4'hE; // sum_with_flag_instruction
    localparam logic [15:0] OP_ALL_ONES = 16'hFFFF; // Always invalid
    localparam logic [31:0] PC_AHEAD = 32'h00000004; // Two instructions on
    localparam logic [4:0] LOOP_TAIL = 5'h03; // Guarded loop tail

    // Exception codes reported per instruction
    typedef enum logic [2:0] {
        CAC_EXC_NONE = 3'b000,
        CAC_EXC_INVALID = 3'b001,
        CAC_EXC_SLOT = 3'b010,
        CAC_EXC_ADDR_RD = 3'b011,
        CAC_EXC_ADDR_WR = 3'b100
    } cac_exc_t;

    // Operand sizes (also the displacement shift)
    typedef enum logic [1:0] {
        CAC_SZ_BYTE = 2'b00,
        CAC_SZ_WORD = 2'b01,
        CAC_SZ_LONG = 2'b10
    } cac_size_t;

    // Displacement addressing modes
    typedef enum logic [1:0] {
        CAC_AM_REG4 = 2'b00, // Register indirect, 4-bit disp
        CAC_AM_BASE8 = 2'b01, // Base register, 8-bit disp
        CAC_AM_PC8 = 2'b10, // PC relative, 8-bit disp
        CAC_AM_PC12 = 2'b11 // PC relative branch, 12-bit disp
    } cac_mode_t;

endpackage : cac_pkg
`default_nettype wire

// ---- design/cac_decode.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Opcode classifier, purely combinational
// ****************************************
module cac_decode (
    input wire logic [15:0] code,
    input wire logic user_mode,
    output logic is_add,
    output logic is_addi,
    output logic is_sum_with_flag_instruction,
    output logic is_invalid,
    output logic is_pc_write,
    output logic is_ctl_write
);
    wire [3:0] top = code[15:12];
    wire [3:0] low = code[3:0];
    wire [7:0] lo8 = code[7:0];
    wire [7:0] hi8 = code[15:8];
    wire reg_grp = (top == cac_pkg::OP_REGOP);

    // Arithmetic forms handled by the datapath
    assign is_add = reg_grp && (low == cac_pkg::LO_ADD);
    assign is_addi = (top == cac_pkg::OP_ADDI);
    assign is_sum_with_flag_instruction = reg_grp && (low == cac_pkg::LO_SUM_WITH_FLAG_INSTRUCTION);

    // Branches, calls, jumps, returns and traps all rewrite the PC
    wire cond_br = (hi8 == 8'h89) || (hi8 == 8'h8B) || (hi8 == 8'h8D) || (hi8 == 8'h8F);
    wire rel_br = (top == 4'hA) || (top == 4'hB);
    wire reg_br = (top == 4'h4) && ((lo8 == 8'h2B) || (lo8 == 8'h0B));
    wire far_br = (top == 4'h0) && ((lo8 == 8'h23) || (lo8 == 8'h03));
    wire ret = (code == 16'h000B) || (code == 16'h002B);
    wire trap = (hi8 == 8'hC3);
    assign is_pc_write = cond_br || rel_br || reg_br || far_br || ret || trap;

    // Writes to status_word, repeat_start_reg or repeat_end_reg
    wire ctl_ld = (top == 4'h4) && ((lo8 == 8'h0E) || (lo8 == 8'h07)
        || (lo8 == 8'h6E) || (lo8 == 8'h7E) || (lo8 == 8'h14));
    wire rep_imm = (hi8 == 8'h82) || (hi8 == 8'h8C) || (hi8 == 8'h8E);
    assign is_ctl_write = ctl_ld || rep_imm;

    // Privileged forms; base-register loads/stores are left open
    wire priv = (code == 16'h002B) || ((top == 4'h4) && ((lo8 == 8'h0E)
        || (lo8 == 8'h07) || (lo8 == 8'h2E))) || ((top == 4'h0) && (lo8 == 8'h22));

    // Holes in the opcode map; all-ones is the canonical one
    wire hole = (code == cac_pkg::OP_ALL_ONES) || (reg_grp && ((low == 4'h1) || (low == 4'h9)));
    assign is_invalid = hole || (user_mode && priv);
endmodule : cac_decode
`default_nettype wire

// ---- design/cac_addr_calc.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Effective address and alignment check
// ****************************************
module cac_addr_calc (
    input wire logic [1:0] mode,
    input wire logic [1:0] size,
    input wire logic [11:0] disp,
    input wire logic [31:0] base,
    input wire logic [31:0] pc_seen,
    output logic [31:0] addr,
    output logic misaligned
);
    // Unsigned field scaled by operand size
    function automatic logic [31:0] scale(input logic [31:0] d, input logic [1:0] sz);
        scale = d << sz;
    endfunction : scale

    wire [31:0] d4 = {28'h0000000, disp[3:0]};
    wire [31:0] d8 = {24'h000000, disp[7:0]};
    wire [31:0] d12 = {{20{disp[11]}}, disp}; // Branch disp is signed

    // Notation is unscaled; hardware scales here
    always_comb begin
        unique case (cac_pkg::cac_mode_t'(mode))
            cac_pkg::CAC_AM_REG4: addr = base + scale(d4, size);
            cac_pkg::CAC_AM_BASE8: addr = base + scale(d8, size);
            cac_pkg::CAC_AM_PC8: addr = pc_seen + scale(d8, size);
            cac_pkg::CAC_AM_PC12: addr = pc_seen + scale(d12, 2'b01);
        endcase
    end

    // Word needs 2n, longword needs 4n
    assign misaligned = ((size == cac_pkg::CAC_SZ_WORD) && addr[0])
        || ((size == cac_pkg::CAC_SZ_LONG) && (addr[1:0] != 2'b00));
endmodule : cac_addr_calc
`default_nettype wire

// ---- design/cac_core.sv ----
`timescale 1ns/1ps
`default_nettype none
module cac_core (
    input wire logic clock,
    input wire logic resetn,
    // Register port
    input wire logic [6:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata_r,
    // Instruction issue
    input wire logic instr_valid,
    input wire logic [15:0] instr_code,
    input wire logic [31:0] instr_addr,
    input wire logic in_slot,
    input wire logic user_mode,
    input wire logic dsp_variant,
    input wire logic loop_active,
    input wire logic [4:0] loop_len,
    input wire logic [4:0] loop_index,
    // Memory access check
    input wire logic acc_valid,
    input wire logic acc_write,
    input wire logic [1:0] acc_mode,
    input wire logic [1:0] acc_size,
    input wire logic [11:0] acc_disp,
    input wire logic [31:0] acc_base,
    // Results
    output logic exc_valid_r,
    output logic [2:0] exc_code_r,
    output logic [31:0] pc_seen_r,
    output logic wb_valid_r,
    output logic [3:0] wb_reg_r,
    output logic [31:0] wb_data_r,
    output logic [31:0] acc_addr_r,
    output logic acc_ok_r
);

    // ****************************************
    // State
    // ****************************************
    logic [31:0] gpr_r [16]; // General registers
    logic [31:0] status_r; // status_word
    logic [2:0] last_exc_r; // Last exception code seen

    // ****************************************
    // Three-input unsigned adder
    // ****************************************
    // Returns {carry, sum}; used for all three add forms
    function automatic logic [32:0] add3(input logic [31:0] a, input logic [31:0] b,
        input logic c);
        add3 = {1'b0, a} + {1'b0, b} + {32'h00000000, c};
    endfunction : add3

    // ****************************************
    // Decode
    // ****************************************
    logic is_add; // Register add
    logic is_addi; // Immediate add
    logic is_sum_with_flag_instruction; // Add with carry
    logic is_invalid; // Map hole or privilege breach
    logic is_pc_write; // Rewrites the PC
    logic is_ctl_write; // Rewrites status or repeat bounds

    cac_decode u_dec (
        .code(instr_code),
        .user_mode(user_mode),
        .is_add(is_add),
        .is_addi(is_addi),
        .is_sum_with_flag_instruction(is_sum_with_flag_instruction),
        .is_invalid(is_invalid),
        .is_pc_write(is_pc_write),
        .is_ctl_write(is_ctl_write)
    );

    // Operand fields
    wire [3:0] dst_idx = instr_code[11:8];
    wire [3:0] src_idx = instr_code[7:4];
    wire [31:0] dst_val = gpr_r[dst_idx];
    wire [31:0] src_val = gpr_r[src_idx];
    wire [31:0] imm_sx = {{24{instr_code[7]}}, instr_code[7:0]};
    wire t_in = status_r[cac_pkg::ST_T];

    // ****************************************
    // Checks on the issued instruction
    // ****************************************
    // Seen PC is two instructions ahead
    wire [31:0] pc_seen = instr_addr + cac_pkg::PC_AHEAD;

    // Slot: branch-type or invalid instruction
    wire slot_bad = in_slot && (is_pc_write || is_invalid);

    // Loop tail covers short loops whole; index counts from 0
    wire [5:0] tail_pos = {1'b0, loop_index} + {1'b0, cac_pkg::LOOP_TAIL};
    wire in_tail = loop_active && (tail_pos >= {1'b0, loop_len});
    wire loop_bad = dsp_variant && in_tail
        && (is_invalid || is_pc_write || is_ctl_write);

    // Slot outranks general invalid: the slot exception is more specific
    wire any_bad = slot_bad || is_invalid || loop_bad;
    wire [2:0] instr_exc = slot_bad ? cac_pkg::CAC_EXC_SLOT
        : (any_bad ? cac_pkg::CAC_EXC_INVALID : cac_pkg::CAC_EXC_NONE);

    // ****************************************
    // Datapath
    // ****************************************
    wire [32:0] sum_rr = add3(dst_val, src_val, 1'b0);
    wire [32:0] sum_ri = add3(dst_val, imm_sx, 1'b0);
    wire [32:0] sum_rc = add3(dst_val, src_val, t_in);

    wire do_exec = instr_valid && !any_bad;
    wire do_wb = do_exec && (is_add || is_addi || is_sum_with_flag_instruction);
    wire [31:0] wb_data = is_sum_with_flag_instruction ? sum_rc[31:0]
        : (is_addi ? sum_ri[31:0] : sum_rr[31:0]);
    // Only add-with-carry touches the flag
    wire t_upd = do_exec && is_sum_with_flag_instruction;
    wire t_new = sum_rc[32];

    // ****************************************
    // Access address check
    // ****************************************
    logic [31:0] acc_addr; // Scaled effective address
    logic acc_mis; // Fails alignment

    cac_addr_calc u_acc (
        .mode(acc_mode),
        .size(acc_size),
        .disp(acc_disp),
        .base(acc_base),
        .pc_seen(pc_seen),
        .addr(acc_addr),
        .misaligned(acc_mis)
    );

    // Branch targets are not data accesses
    wire acc_err = acc_valid && acc_mis
        && (acc_mode != cac_pkg::CAC_AM_PC12);
    wire [2:0] acc_exc = acc_write ? cac_pkg::CAC_EXC_ADDR_WR
        : cac_pkg::CAC_EXC_ADDR_RD;

    // Instruction exceptions outrank address errors in one cycle
    wire ins_exc = instr_valid && any_bad;
    wire exc_now = ins_exc || acc_err;
    wire [2:0] exc_code = ins_exc ? instr_exc : acc_exc;

    // ****************************************
    // Register port decode
    // ****************************************
    wire sel_status = (reg_addr == cac_pkg::OFF_STATUS);
    wire sel_exc = (reg_addr == cac_pkg::OFF_EXC);
    wire sel_pc = (reg_addr == cac_pkg::OFF_PCSEEN);
    wire sel_acc = (reg_addr == cac_pkg::OFF_ACCADDR);
    wire sel_gpr = (reg_addr[6] == cac_pkg::OFF_GPR[6]);
    wire [3:0] gpr_sel = reg_addr[5:2];

    // Unmapped offsets below 0x40 read as zero; every offset from 0x40 up reads a general register
    logic [31:0] rd_mux;
    always_comb begin
        if (sel_status) begin
            rd_mux = status_r & cac_pkg::ST_MASK;
        end else if (sel_exc) begin
            rd_mux = {29'h00000000, last_exc_r};
        end else if (sel_pc) begin
            rd_mux = pc_seen_r;
        end else if (sel_acc) begin
            rd_mux = acc_addr_r;
        end else if (sel_gpr) begin
            rd_mux = gpr_r[gpr_sel];
        end else begin
            rd_mux = 32'h00000000;
        end
    end

    // Status write from software, flag then overlaid by execution
    wire [31:0] status_sw = reg_wdata & cac_pkg::ST_MASK;
    wire [31:0] status_base = (reg_wr && sel_status) ? status_sw : status_r;
    wire [31:0] status_nxt = t_upd
        ? {status_base[31:1], t_new} : status_base;

    // ****************************************
    // Status word and read data
    // ****************************************
    // Execution wins a same-cycle clash on the flag
    always_ff @(posedge clock) begin
        if (!resetn) begin
            status_r <= cac_pkg::ST_RESET;
        end else begin
            status_r <= status_nxt;
        end
    end

    // Read data stands for one cycle only
    always_ff @(posedge clock) begin
        if (!resetn) begin
            reg_rdata_r <= 32'h00000000;
        end else begin
            reg_rdata_r <= reg_rd ? rd_mux : 32'h00000000;
        end
    end

    // ****************************************
    // General registers
    // ****************************************
    // Write-back wins over software on the same register
    always_ff @(posedge clock) begin
        if (!resetn) begin
            for (int i = 0; i < 16; i++) begin
                gpr_r[i] <= 32'h00000000;
            end
        end else begin
            // Software first; a later write-back to the same register wins
            if (reg_wr && sel_gpr) begin
                gpr_r[gpr_sel] <= reg_wdata;
            end
            if (do_wb) begin
                gpr_r[dst_idx] <= wb_data;
            end
        end
    end

    // ****************************************
    // Result outputs
    // ****************************************
    // Exception report pulses one cycle
    always_ff @(posedge clock) begin
        if (!resetn) begin
            exc_valid_r <= 1'b0;
            exc_code_r <= cac_pkg::CAC_EXC_NONE;
            last_exc_r <= cac_pkg::CAC_EXC_NONE;
        end else begin
            exc_valid_r <= exc_now;
            exc_code_r <= exc_now ? exc_code : cac_pkg::CAC_EXC_NONE;
            if (exc_now) begin
                last_exc_r <= exc_code;
            end
        end
    end

    // PC seen by each issued instruction
    always_ff @(posedge clock) begin
        if (!resetn) begin
            pc_seen_r <= 32'h00000000;
        end else if (instr_valid) begin
            pc_seen_r <= pc_seen;
        end
    end

    // Write-back report, one cycle per add
    always_ff @(posedge clock) begin
        if (!resetn) begin
            wb_valid_r <= 1'b0;
            wb_reg_r <= 4'h0;
            wb_data_r <= 32'h00000000;
        end else begin
            wb_valid_r <= do_wb;
            if (do_wb) begin
                wb_reg_r <= dst_idx;
                wb_data_r <= wb_data;
            end
        end
    end

    // Checked access address and its verdict
    always_ff @(posedge clock) begin
        if (!resetn) begin
            acc_addr_r <= 32'h00000000;
            acc_ok_r <= 1'b0;
        end else begin
            acc_ok_r <= acc_valid && !acc_err;
            if (acc_valid) begin
                acc_addr_r <= acc_addr;
            end
        end
    end

endmodule : cac_core
`default_nettype wire

// ---- testbench/cac_core_props.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Port-level checks of the add/slot core
// ****************************************
module cac_core_props (
    input wire logic clock,
    input wire logic resetn,
    input wire logic instr_valid,
    input wire logic [15:0] instr_code,
    input wire logic [31:0] instr_addr,
    input wire logic in_slot,
    input wire logic dsp_variant,
    input wire logic loop_active,
    input wire logic [4:0] loop_len,
    input wire logic [4:0] loop_index,
    input wire logic acc_valid,
    input wire logic acc_write,
    input wire logic [1:0] acc_mode,
    input wire logic [1:0] acc_size,
    input wire logic [11:0] acc_disp,
    input wire logic [31:0] acc_base,
    input wire logic exc_valid_r,
    input wire logic [2:0] exc_code_r,
    input wire logic [31:0] pc_seen_r,
    input wire logic wb_valid_r,
    input wire logic [3:0] wb_reg_r,
    input wire logic [31:0] acc_addr_r,
    input wire logic acc_ok_r
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);
    // Expected scaled address, register and base modes only
    logic [31:0] want_addr;
    logic [31:0] disp_ext;
    logic mis;
    assign disp_ext = acc_mode[0] ? {24'h0, acc_disp[7:0]} : {28'h0, acc_disp[3:0]};
    assign want_addr = acc_base + (disp_ext << acc_size);
    assign mis = (acc_size == 2'h1 && want_addr[0]) || (acc_size == 2'h2 && want_addr[1:0] != 2'h0);
    property p_pc_ahead;
        instr_valid |=> pc_seen_r == $past(instr_addr) + 32'h4;
    endproperty
    a_pc_ahead: assert property (p_pc_ahead) else $error("pc seen wrong");
    property p_scale;
        acc_valid && !acc_mode[1] |=> acc_addr_r == $past(want_addr);
    endproperty
    a_scale: assert property (p_scale) else $error("scaled address wrong");
    property p_mis;
        acc_valid && !instr_valid && !acc_mode[1] && mis
            |=> exc_valid_r && exc_code_r == ($past(acc_write) ? 3'h4 : 3'h3);
    endproperty
    a_mis: assert property (p_mis) else $error("no address error");
    property p_ok;
        acc_valid && !instr_valid && !acc_mode[1] && !mis |=> acc_ok_r && !exc_valid_r;
    endproperty
    a_ok: assert property (p_ok) else $error("aligned access refused");
    property p_slot;
        instr_valid && in_slot && (instr_code[15:12] == 4'hA || instr_code == 16'hFFFF)
            |=> exc_valid_r && exc_code_r == 3'h2;
    endproperty
    a_slot: assert property (p_slot) else $error("slot fault missed");
    property p_invalid;
        instr_valid && !in_slot && instr_code == 16'hFFFF |=> exc_valid_r && exc_code_r == 3'h1;
    endproperty
    a_invalid: assert property (p_invalid) else $error("invalid opcode missed");
    property p_loop;
        instr_valid && !in_slot && dsp_variant && loop_active && instr_code[15:12] == 4'hA
            && ({1'b0, loop_index} + 6'h3 >= {1'b0, loop_len}) |=> exc_code_r == 3'h1;
    endproperty
    a_loop: assert property (p_loop) else $error("loop tail fault missed");
    property p_clean;
        exc_valid_r |-> !wb_valid_r;
    endproperty
    a_clean: assert property (p_clean) else $error("faulting write back");
    property p_add;
        instr_valid && instr_code[15:12] == 4'h3 && instr_code[3:0] == 4'hC
            |=> wb_valid_r && wb_reg_r == $past(instr_code[11:8]);
    endproperty
    a_add: assert property (p_add) else $error("add write back wrong");
endmodule : cac_core_props
bind cac_core cac_core_props chk_u (.clock, .resetn, .instr_valid, .instr_code, .instr_addr,
    .in_slot, .dsp_variant, .loop_active, .loop_len, .loop_index, .acc_valid, .acc_write,
    .acc_mode, .acc_size, .acc_disp, .acc_base, .exc_valid_r, .exc_code_r, .pc_seen_r,
    .wb_valid_r, .wb_reg_r, .acc_addr_r, .acc_ok_r);
`default_nettype wire

// ---- testbench/cac_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Memory side issuing access checks
// ****************************************
module cac_mem_model (
    input wire logic clock,
    output logic acc_valid,
    output logic acc_write,
    output logic [1:0] acc_mode,
    output logic [1:0] acc_size,
    output logic [11:0] acc_disp,
    output logic [31:0] acc_base
);
    // Idle at time zero
    initial begin
        acc_valid = 1'b0;
        acc_write = 1'b0;
        acc_mode = 2'h0;
        acc_size = 2'h0;
        acc_disp = 12'h000;
        acc_base = 32'h00000000;
    end
    // One-cycle request; stale disp and base inverted so neither looks valid
    task automatic access(input logic w, input logic [1:0] m, input logic [1:0] s,
        input logic [11:0] d, input logic [31:0] b);
        @(posedge clock);
        acc_valid <= 1'b1;
        acc_write <= w;
        acc_mode <= m;
        acc_size <= s;
        acc_disp <= d;
        acc_base <= b;
        @(posedge clock);
        acc_valid <= 1'b0;
        acc_disp <= ~d;
        acc_base <= ~b;
        #1;
    endtask : access
endmodule : cac_mem_model
`default_nettype wire

// ---- testbench/tb_cac_core.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; $display("ERROR %s exp %h got %h", n, e, g); end end
module tb_cac_core;
    // ****************************************
    // Stimulus and observed signals
    // ****************************************
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic [6:0] reg_addr = 7'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic instr_valid = 1'b0;
    logic [15:0] instr_code = 16'h0;
    logic [31:0] instr_addr = 32'h0;
    logic in_slot = 1'b0;
    logic user_mode = 1'b0;
    logic dsp_variant = 1'b0;
    logic loop_active = 1'b0;
    logic [4:0] loop_len = 5'h00;
    logic [4:0] loop_index = 5'h00;
    wire logic acc_valid, acc_write;
    wire logic [1:0] acc_mode, acc_size;
    wire logic [11:0] acc_disp;
    wire logic [31:0] acc_base;
    logic [31:0] reg_rdata_r, pc_seen_r, wb_data_r, acc_addr_r;
    logic exc_valid_r, wb_valid_r, acc_ok_r;
    logic [2:0] exc_code_r;
    logic [3:0] wb_reg_r;
    int error_cnt = 0;
    int checks = 0;
    logic [31:0] ia = 32'h00001000; // Next instruction address
    // Branch-type codes that are illegal in a delay slot
    logic [15:0] slot_ops [13] = '{16'h8B10, 16'h8910, 16'hA123, 16'hB123, 16'h432B,
        16'h430B, 16'h000B, 16'h002B, 16'hC320, 16'h0323, 16'h0303, 16'h8D10, 16'h8F10};
    cac_core dut_u (.clock, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_r,
        .instr_valid, .instr_code, .instr_addr, .in_slot, .user_mode, .dsp_variant,
        .loop_active, .loop_len, .loop_index, .acc_valid, .acc_write, .acc_mode, .acc_size,
        .acc_disp, .acc_base, .exc_valid_r, .exc_code_r, .pc_seen_r, .wb_valid_r, .wb_reg_r,
        .wb_data_r, .acc_addr_r, .acc_ok_r);
    cac_mem_model mem_u (.clock, .acc_valid, .acc_write, .acc_mode, .acc_size, .acc_disp,
        .acc_base);
    // 25 MHz clock
    initial begin
        forever #20 clock = ~clock;
    end
    // ****************************************
    // Access tasks
    // ****************************************
    function automatic logic [6:0] ga(input logic [3:0] i);
        return cac_pkg::OFF_GPR + {1'b0, i, 2'b00};
    endfunction : ga
    task automatic wr(input logic [6:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [6:0] a, input logic [31:0] e);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        `CHK("reg", e, reg_rdata_r)
    endtask : rd
    task automatic run(input logic [15:0] c, input logic s, input logic [2:0] e);
        @(posedge clock);
        instr_valid <= 1'b1;
        instr_code <= c;
        instr_addr <= ia;
        in_slot <= s;
        @(posedge clock);
        instr_valid <= 1'b0;
        in_slot <= 1'b0;
        #1;
        `CHK("exc", e, exc_code_r)
        `CHK("exc_valid", e != 3'h0, exc_valid_r)
        `CHK("pc_seen", ia + 32'h4, pc_seen_r)
        ia = ia + 32'h2;
    endtask : run
    task automatic wb(input logic [3:0] r, input logic [31:0] d);
        `CHK("wb_valid", 1'b1, wb_valid_r)
        `CHK("wb_reg", r, wb_reg_r)
        `CHK("wb_data", d, wb_data_r)
    endtask : wb
    task automatic acc(input logic w, input logic [1:0] m, input logic [1:0] s,
        input logic [11:0] d, input logic [31:0] b, input logic [31:0] ea, input logic [2:0] e);
        mem_u.access(w, m, s, d, b);
        `CHK("acc_addr", ea, acc_addr_r)
        `CHK("acc_ok", e == 3'h0, acc_ok_r)
        `CHK("acc_exc", e, exc_code_r)
    endtask : acc
    task automatic close_out;
        if (error_cnt == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out
    // Hang guard, far beyond the 125 or so cycles used
    initial begin
        #200000;
        error_cnt++;
        close_out();
    end
    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        rd(cac_pkg::OFF_STATUS, 32'h00000000);
        rd(7'h30, 32'h0);
        wr(cac_pkg::OFF_STATUS, 32'hFFFFFFFF);
        rd(cac_pkg::OFF_STATUS, 32'h0FFF0FFF);
        // Add keeps the flag set
        wr(cac_pkg::OFF_STATUS, 32'h1);
        wr(ga(1), 32'h7FFFFFFF);
        wr(ga(2), 32'h1);
        run(16'h312C, 1'b0, 3'h0);
        wb(4'h1, 32'h80000000);
        rd(cac_pkg::OFF_STATUS, 32'h1);
        wr(ga(3), 32'h1);
        run(16'h73FE, 1'b0, 3'h0);
        wb(4'h3, 32'hFFFFFFFF);
        run(16'h7201, 1'b0, 3'h0);
        wb(4'h2, 32'h2);
        // Multiword add chain
        wr(cac_pkg::OFF_STATUS, 32'h0);
        wr(ga(1), 32'h1);
        run(16'h313E, 1'b0, 3'h0);
        wb(4'h1, 32'h0);
        rd(cac_pkg::OFF_STATUS, 32'h1);
        wr(ga(0), 32'h0);
        wr(ga(2), 32'h0);
        run(16'h302E, 1'b0, 3'h0);
        wb(4'h0, 32'h1);
        rd(cac_pkg::OFF_STATUS, 32'h0);
        // Carry born only from the incoming flag
        wr(cac_pkg::OFF_STATUS, 32'h1);
        wr(ga(4), 32'hFFFFFFFF);
        wr(ga(5), 32'h0);
        run(16'h345E, 1'b0, 3'h0);
        wb(4'h4, 32'h0);
        rd(cac_pkg::OFF_STATUS, 32'h1);
        rd(ga(4), 32'h0);
        run(16'hFFFF, 1'b0, 3'h1);
        `CHK("wb_valid", 1'b0, wb_valid_r)
        run(16'h3121, 1'b0, 3'h1);
        `CHK("wb_valid", 1'b0, wb_valid_r)
        user_mode <= 1'b1;
        run(16'h002B, 1'b0, 3'h1);
        run(16'h401E, 1'b0, 3'h0);
        user_mode <= 1'b0;
        for (int i = 0; i < 13; i++) begin
            run(slot_ops[i], 1'b1, 3'h2);
        end
        run(16'hFFFF, 1'b1, 3'h2);
        run(16'h312C, 1'b1, 3'h0);
        // Repeat loop tail checks
        dsp_variant <= 1'b1;
        loop_active <= 1'b1;
        loop_len <= 5'h03;
        run(16'h8C00, 1'b0, 3'h1);
        loop_len <= 5'h08;
        loop_index <= 5'h02;
        run(16'h8C00, 1'b0, 3'h0);
        loop_index <= 5'h05;
        run(16'hA000, 1'b0, 3'h1);
        loop_index <= 5'h04;
        run(16'hA000, 1'b0, 3'h0);
        dsp_variant <= 1'b0;
        loop_index <= 5'h05;
        run(16'h8C00, 1'b0, 3'h0);
        loop_active <= 1'b0;
        rd(cac_pkg::OFF_PCSEEN, ia + 32'h2);
        // Alignment and scaling
        acc(1'b0, 2'h0, 2'h1, 12'h000, 32'h101, 32'h101, 3'h3);
        acc(1'b1, 2'h0, 2'h2, 12'h000, 32'h102, 32'h102, 3'h4);
        acc(1'b1, 2'h1, 2'h1, 12'h000, 32'h103, 32'h103, 3'h4);
        acc(1'b0, 2'h0, 2'h2, 12'h001, 32'h100, 32'h104, 3'h0);
        acc(1'b1, 2'h1, 2'h1, 12'h010, 32'h300, 32'h320, 3'h0);
        acc(1'b0, 2'h0, 2'h0, 12'h003, 32'h003, 32'h006, 3'h0);
        acc(1'b0, 2'h2, 2'h0, 12'h001, 32'h0, ia + 32'h3, 3'h0);
        acc(1'b0, 2'h3, 2'h0, 12'hFFF, 32'h0, ia, 3'h0);
        rd(cac_pkg::OFF_EXC, 32'h4);
        rd(cac_pkg::OFF_ACCADDR, ia);
        close_out();
    end
endmodule : tb_cac_core
`default_nettype wire
